// ==== lmm_host.sv ====
// Host board controller model on the two-wire bus
`timescale 1ns/1ps
module lmm_host (
   // Two-wire bus, clock idles high between frames
   output logic      scl,
   output logic      sda_oe,
   input  wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // One clock of 160 ns: data set while low, sampled at the rise
   task automatic bit_io(input logic b, output logic r);
      scl = 1'b0;
      #20 sda_oe = ~b;
      #60 scl = 1'b1;
      r = sda;
      #80;
   endtask
   // Odd lead-in keeps every bus edge off the core clock edges
   task automatic start();
      #83 sda_oe = 1'b1;
      #80;
   endtask
   task automatic stop();
      scl = 1'b0;
      #20 sda_oe = 1'b1;
      #60 scl = 1'b1;
      #80 sda_oe = 1'b0;
      #80;
   endtask
   // Byte out MSB first, then the slave's acknowledge
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // Byte in, then acknowledge or, on the last byte, no acknowledge
   task automatic get(output logic [7:0] d, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule

// ==== lmm_pkg.sv ====
// Types shared by the module management logic
package lmm_pkg;

   // Serial protocol states
   typedef enum logic [2:0] {
      LMM_IDLE,
      LMM_ADDR,
      LMM_PTR,
      LMM_WRITE,
      LMM_READ
   } lmm_state_t;

   // Drive pair of an open-drain pin: level and enable
   typedef struct packed {
      logic level;
      logic oe;
   } lmm_drive_t;

endpackage

// ==== lmm_regs.svh ====
// Offsets, field positions, reset values and timing counts of the management block
`ifndef LMM_REGS_SVH
`define LMM_REGS_SVH

// Two-wire slave address of the module memory map
`define LMM_DEV_ADDR         7'h50

// Memory map byte offsets
`define LMM_OFS_IDENT        8'h00
`define LMM_OFS_FLAGS        8'h01
`define LMM_OFS_STATUS       8'h02
`define LMM_OFS_CONTROL      8'h03

// Field positions
`define LMM_FLAG_RESET_DONE  0
`define LMM_FLAG_FAULT       1
`define LMM_STAT_NOT_READY   0
`define LMM_CTRL_LP_FORCE    0
`define LMM_CTRL_LP_OVERRIDE 1

// Reset values
`define LMM_CONTROL_RST      8'h00
`define LMM_FLAGS_RST        8'h00
`define LMM_PTR_RST          8'h00

// Timing: clock period, least reset pulse, time spent initialising after a reset
`define LMM_CLK_PERIOD_NS    25
`define LMM_RESET_MIN_NS     10000
`define LMM_INIT_NS          2000
`define LMM_RESET_MIN_CYC    ((`LMM_RESET_MIN_NS + `LMM_CLK_PERIOD_NS - 1) / `LMM_CLK_PERIOD_NS)
`define LMM_INIT_CYC         ((`LMM_INIT_NS + `LMM_CLK_PERIOD_NS - 1) / `LMM_CLK_PERIOD_NS)
`define LMM_TIMER_W          12

`endif

// ==== lmm_top.sv ====
// Low-speed management logic of a pluggable module: two-wire slave, reset, present, interrupt
`timescale 1ns/1ps
`include "lmm_regs.svh"

// Behaviour
// - Seven low-speed pins: select, serial clock and data, reset, low power, present, interrupt.
// - The module answers serial commands only while the host holds module select low.
// - A reset pin held low longer than the least pulse length restores the control, flag, pointer and bus state defaults.
// - At the end of a reset the module raises its interrupt and clears the not-ready bit.
// - After power-up the module posts the completion interrupt without any reset pulse.
// - The low-power input sets the permitted maximum power consumption of the module unless the control override bit is set.
// - A fitted module grounds the present line so the host sees it low.
// - The module pulls its open-collector interrupt low to report a fault or critical status.
module lmm_top
   import lmm_pkg::*;
#(
   parameter logic [7:0] IDENT_CODE = 8'h5a  // Arbitrary identifier value
) (
   // Core clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Two-wire serial bus
   input  wire logic scl,
   input  wire logic sda_i,
   output lmm_drive_t sda_drv,
   // Module control pins
   input  wire logic module_select_n,
   input  wire logic module_reset_n,
   input  wire logic low_power_request,
   output logic      module_present_n,
   output lmm_drive_t interrupt_drv,
   // Internal status towards the datapath
   input  wire logic fault_event,
   output logic      low_power_mode,
   output logic      module_ready
);

   // Link domain: byte shifter clocked by the serial clock
   logic [7:0]       link_shift_q;

   // Pin synchronisers
   logic [1:0]       scl_sync_q;
   logic [1:0]       sda_sync_q;
   logic [1:0]       sel_sync_q;
   logic [1:0]       mrst_sync_q;
   logic [1:0]       lp_sync_q;
   logic             scl_prev_q;
   logic             sda_prev_q;

   // Protocol state
   lmm_state_t       state_q, state_d;
   logic [3:0]       bit_cnt_q, bit_cnt_d;
   logic             ack_q, ack_d;
   logic [7:0]       ptr_q, ptr_d;
   logic [7:0]       tx_q, tx_d;
   logic             sda_oe_q, sda_oe_d;

   // Memory map state
   logic [7:0]       ctrl_q, ctrl_d;
   logic [7:0]       flags_q, flags_d;
   logic             not_ready_q, not_ready_d;
   logic [`LMM_TIMER_W-1:0] hold_cnt_q, hold_cnt_d;
   logic [`LMM_TIMER_W-1:0] init_cnt_q, init_cnt_d;

   // Pin outputs
   logic             int_oe_q;
   logic             lp_mode_q, ready_q;

   // Memory map read decode, used only for the outgoing byte
   function automatic logic [7:0] map_read(input logic [7:0] ofs, input logic [7:0] flags,
                                            input logic nrdy, input logic [7:0] ctrl);
      logic [7:0] val;
      val = 8'h00;
      unique case (ofs)
         `LMM_OFS_IDENT:   val = IDENT_CODE;
         `LMM_OFS_FLAGS:   val = flags;
         `LMM_OFS_STATUS:  val = {7'h00, nrdy};
         `LMM_OFS_CONTROL: val = ctrl;
         default:          val = 8'h00;
      endcase
      return val;
   endfunction

   // Serial data sampled on each rising serial clock edge
   always_ff @(posedge scl) begin
      link_shift_q <= {link_shift_q[6:0], sda_i};
   end

   // Two-stage synchronisers for every pin input
   always_ff @(posedge core_clk) begin
      scl_sync_q  <= {scl_sync_q[0], scl};
      sda_sync_q  <= {sda_sync_q[0], sda_i};
      sel_sync_q  <= {sel_sync_q[0], module_select_n};
      mrst_sync_q <= {mrst_sync_q[0], module_reset_n};
      lp_sync_q   <= {lp_sync_q[0], low_power_request};
      scl_prev_q  <= scl_sync_q[1];
      sda_prev_q  <= sda_sync_q[1];
   end

   // Bus events seen in the core domain
   wire scl_s      = scl_sync_q[1];
   wire sda_s      = sda_sync_q[1];
   wire selected   = ~sel_sync_q[1];
   wire scl_rise   = scl_s & ~scl_prev_q;
   wire scl_fall   = ~scl_s & scl_prev_q;
   wire bus_start  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   wire bus_stop   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   wire byte_done  = scl_rise & (bit_cnt_q == 4'h7);
   wire ack_slot   = scl_rise & (bit_cnt_q == 4'h8);
   wire addr_hit   = (link_shift_q[7:1] == `LMM_DEV_ADDR);

   // Module reset pin: low for the least pulse length gives a full reset
   wire pin_reset  = hold_cnt_q == `LMM_TIMER_W'(`LMM_RESET_MIN_CYC);
   wire init_done  = not_ready_q & (init_cnt_q == `LMM_TIMER_W'(`LMM_INIT_CYC));

   // Read of the flag byte clears the flags it returned
   wire rd_load    = (state_q == LMM_READ) & ack_slot & (ack_q | ~sda_s);
   wire flags_rd   = rd_load & (ptr_q == `LMM_OFS_FLAGS);
   wire map_wr     = (state_q == LMM_WRITE) & byte_done & selected;
   wire [7:0] rd_byte = map_read(ptr_q, flags_q, not_ready_q, ctrl_q);

   // Reset timing and ready status
   always_comb begin
      hold_cnt_d  = hold_cnt_q;
      init_cnt_d  = init_cnt_q;
      not_ready_d = not_ready_q;
      if (mrst_sync_q[1]) begin
         hold_cnt_d = '0;
      end else if (!pin_reset) begin
         hold_cnt_d = hold_cnt_q + 1'b1;
      end
      if (pin_reset) begin
         not_ready_d = 1'b1;
         init_cnt_d  = '0;
      end else if (init_done) begin
         not_ready_d = 1'b0;
      end else if (not_ready_q) begin
         init_cnt_d = init_cnt_q + 1'b1;
      end
   end

   // Flags and control byte; a set in the cycle of a clearing read wins
   always_comb begin
      flags_d = flags_q;
      ctrl_d  = ctrl_q;
      if (flags_rd) begin
         flags_d = `LMM_FLAGS_RST;
      end
      if (init_done) begin
         flags_d[`LMM_FLAG_RESET_DONE] = 1'b1;
      end
      if (fault_event) begin
         flags_d[`LMM_FLAG_FAULT] = 1'b1;
      end
      if (map_wr && ptr_q == `LMM_OFS_CONTROL) begin
         ctrl_d = link_shift_q;
      end
      if (pin_reset) begin
         flags_d = `LMM_FLAGS_RST;
         ctrl_d  = `LMM_CONTROL_RST;
      end
   end

   // Two-wire slave protocol
   always_comb begin
      state_d   = state_q;
      bit_cnt_d = bit_cnt_q;
      ack_d     = ack_q;
      ptr_d     = ptr_q;
      tx_d      = tx_q;
      sda_oe_d  = sda_oe_q;
      if (scl_rise) begin
         bit_cnt_d = (bit_cnt_q == 4'h8) ? 4'h0 : bit_cnt_q + 4'h1;
      end
      if (byte_done) begin
         unique case (state_q)
            LMM_ADDR: begin
               ack_d   = addr_hit;
               state_d = !addr_hit ? LMM_IDLE : (link_shift_q[0] ? LMM_READ : LMM_PTR);
            end
            LMM_PTR: begin
               ptr_d   = link_shift_q;
               ack_d   = 1'b1;
               state_d = LMM_WRITE;
            end
            LMM_WRITE: begin
               ptr_d = ptr_q + 8'h01;
               ack_d = 1'b1;
            end
            LMM_IDLE, LMM_READ: begin
               ack_d = 1'b0;
            end
         endcase
      end
      if (ack_slot) begin
         ack_d = 1'b0;
         if (state_q == LMM_READ && !rd_load) begin
            state_d = LMM_IDLE;  // Host refused the byte
         end
      end
      if (rd_load) begin
         tx_d  = rd_byte;
         ptr_d = ptr_q + 8'h01;
      end
      // Data driven only on a falling clock edge; start, stop, deselect or module reset can release it while clock is high
      if (scl_fall) begin
         if (bit_cnt_q == 4'h8) begin
            sda_oe_d = ack_q;
         end else if (state_q == LMM_READ) begin
            sda_oe_d = ~tx_q[7];
            tx_d     = {tx_q[6:0], 1'b0};
         end else begin
            sda_oe_d = 1'b0;
         end
      end
      if (bus_start) begin
         state_d   = selected ? LMM_ADDR : LMM_IDLE;
         bit_cnt_d = 4'h0;
         ack_d     = 1'b0;
         sda_oe_d  = 1'b0;
      end
      if (bus_stop || !selected) begin
         state_d  = LMM_IDLE;
         ack_d    = 1'b0;
         sda_oe_d = 1'b0;
      end
      if (pin_reset) begin
         state_d  = LMM_IDLE;
         ptr_d    = `LMM_PTR_RST;
         sda_oe_d = 1'b0;
      end
   end

   // Core registers; power-up leaves the module not ready so completion is posted
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q     <= LMM_IDLE;
         bit_cnt_q   <= 4'h0;
         ack_q       <= 1'b0;
         ptr_q       <= `LMM_PTR_RST;
         tx_q        <= 8'h00;
         sda_oe_q    <= 1'b0;
         ctrl_q      <= `LMM_CONTROL_RST;
         flags_q     <= `LMM_FLAGS_RST;
         not_ready_q <= 1'b1;
         hold_cnt_q  <= '0;
         init_cnt_q  <= '0;
      end else begin
         state_q     <= state_d;
         bit_cnt_q   <= bit_cnt_d;
         ack_q       <= ack_d;
         ptr_q       <= ptr_d;
         tx_q        <= tx_d;
         sda_oe_q    <= sda_oe_d;
         ctrl_q      <= ctrl_d;
         flags_q     <= flags_d;
         not_ready_q <= not_ready_d;
         hold_cnt_q  <= hold_cnt_d;
         init_cnt_q  <= init_cnt_d;
      end
   end

   // Pin output registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         int_oe_q  <= 1'b0;
         lp_mode_q <= 1'b1;
         ready_q   <= 1'b0;
      end else begin
         int_oe_q  <= |flags_d;
         lp_mode_q <= ctrl_d[`LMM_CTRL_LP_OVERRIDE] ? ctrl_d[`LMM_CTRL_LP_FORCE]
                                                    : lp_sync_q[1];
         ready_q   <= ~not_ready_d;
      end
   end

   // Output pins; open-drain levels are always low, enables decide
   // five output signals
   assign sda_drv             = '{level: 1'b0, oe: sda_oe_q};
   assign interrupt_drv       = '{level: 1'b0, oe: int_oe_q};
   assign module_present_n    = 1'b0;
   assign low_power_mode      = lp_mode_q;
   assign module_ready        = ready_q;

endmodule

// ==== lmm_top_sva.sv ====
// Port checks of the module management logic
`timescale 1ns/1ps
module lmm_top_sva
   import lmm_pkg::*;
(
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       rst_n,
   // Pins and status
   input wire logic       scl,
   input wire logic       module_select_n,
   input wire logic       module_reset_n,
   input wire logic       fault_event,
   input wire lmm_drive_t sda_drv,
   input wire lmm_drive_t interrupt_drv,
   input wire logic       module_present_n,
   input wire logic       low_power_mode,
   input wire logic       module_ready
);
   logic [9:0] lo_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Cycles the reset pin has stayed low, saturating
   always_ff @(posedge core_clk) begin
      if (module_reset_n)
         lo_q <= 10'h000;
      else if (lo_q != 10'h3ff)
         lo_q <= lo_q + 10'h001;
   end
   property p_present; module_present_n == 1'b0; endproperty
   a_present: assert property (p_present) else $error("present not low");
   property p_od; interrupt_drv.level == 1'b0 && sda_drv.level == 1'b0; endproperty
   a_od: assert property (p_od) else $error("open drain level high");
   property p_rst; disable iff (1'b0) !rst_n |=> !module_ready && !interrupt_drv.oe
      && !sda_drv.oe && low_power_mode; endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_boot; $rose(rst_n) |-> ##76 !module_ready ##[1:8] module_ready; endproperty
   a_boot: assert property (p_boot) else $error("ready timing wrong");
   property p_done; $rose(module_ready) |-> ##[1:2] interrupt_drv.oe; endproperty
   a_done: assert property (p_done) else $error("no completion interrupt");
   property p_fault; fault_event |-> ##[1:3] interrupt_drv.oe; endproperty
   a_fault: assert property (p_fault) else $error("fault not reported");
   property p_pin; $fell(module_ready) |-> lo_q >= 10'h190; endproperty
   a_pin: assert property (p_pin) else $error("short reset pulse acted");
   property p_desel; module_select_n [*6] |-> !sda_drv.oe; endproperty
   a_desel: assert property (p_desel) else $error("drive while deselected");
   // The drive is launched while the clock is low; it is seen one core cycle later
   property p_ack; $rose(sda_drv.oe) |-> !module_select_n && !$past(scl); endproperty
   a_ack: assert property (p_ack) else $error("drive started wrongly");
   c_ack: cover property ($rose(sda_drv.oe));
   c_ready: cover property ($rose(module_ready));
   c_pin: cover property ($fell(module_ready));
endmodule
bind lmm_top lmm_top_sva u_sva (.core_clk(core_clk), .rst_n(rst_n), .scl(scl),
   .module_select_n(module_select_n), .module_reset_n(module_reset_n),
   .fault_event(fault_event), .sda_drv(sda_drv), .interrupt_drv(interrupt_drv),
   .module_present_n(module_present_n), .low_power_mode(low_power_mode),
   .module_ready(module_ready));

// ==== lmm_top_tb_top.sv ====
// Self-checking bench of the module management logic
`timescale 1ns/1ps
module lmm_top_tb_top
   import lmm_pkg::*;
;
   typedef struct packed {
      logic [7:0] ctrl;
      logic       pin;
      logic       lp;
   } lmm_row_t;
   localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value
   lmm_row_t   rows [4] = '{'{8'h00, 1'b0, 1'b0}, '{8'h00, 1'b1, 1'b1},
                            '{8'h02, 1'b1, 1'b0}, '{8'h03, 1'b0, 1'b1}};
   logic       core_clk, rst_n, scl, host_oe, sda, module_present_n, ack;
   logic       module_select_n, module_reset_n, low_power_request, fault_event;
   logic       low_power_mode, module_ready;
   logic [7:0] rd_q;
   lmm_drive_t sda_drv, interrupt_drv;
   int         n_mismatch = 0;
   int         n_tests = 0;
   // Pulled-up data wire
   assign sda = ~(host_oe | sda_drv.oe);
   lmm_top #(.IDENT_CODE(ID)) dut (.core_clk(core_clk), .rst_n(rst_n), .scl(scl),
      .sda_i(sda), .sda_drv(sda_drv), .module_select_n(module_select_n),
      .module_reset_n(module_reset_n), .low_power_request(low_power_request),
      .module_present_n(module_present_n), .interrupt_drv(interrupt_drv),
      .fault_event(fault_event), .low_power_mode(low_power_mode), .module_ready(module_ready));
   lmm_host host (.scl(scl), .sda_oe(host_oe), .sda(sda));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Address and pointer, data byte optional, each acknowledged
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input bit wd);
      host.start();
      host.put(8'ha0, ack);
      chk({7'h00, ack}, 8'h01);
      host.put(ofs, ack);
      chk({7'h00, ack}, 8'h01);
      if (wd) begin
         host.put(d, ack);
         chk({7'h00, ack}, 8'h01);
      end
      host.stop();
   endtask
   task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
      wr(ofs, 8'h00, 1'b0);
      host.start();
      host.put(8'ha1, ack);
      host.get(rd_q, 1'b1);
      host.stop();
      chk(rd_q, exp);
   endtask
   // Frame that must go unanswered
   task automatic no_ack(input logic [7:0] a);
      host.start();
      host.put(a, ack);
      host.stop();
      chk({7'h00, ack}, 8'h00);
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 200 && module_ready !== 1'b1; i++)
         @(posedge core_clk);
      chk({7'h00, module_ready}, 8'h01);
   endtask
   task automatic complete_run();
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog
   initial begin
      #1000000;
      n_mismatch++;
      complete_run();
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      module_select_n = 1'b1;
      module_reset_n = 1'b1;
      low_power_request = 1'b0;
      fault_event = 1'b0;
      cyc(5);
      chk({4'h0, module_present_n, interrupt_drv.oe, sda_drv.oe, module_ready}, 8'h00);
      rst_n <= 1'b1;
      module_select_n <= 1'b0;
      wait_ready();
      cyc(3);
      chk({7'h00, interrupt_drv.oe}, 8'h01);
      rd(8'h02, 8'h00);
      rd(8'h01, 8'h01);
      cyc(4);
      chk({7'h00, interrupt_drv.oe}, 8'h00);
      rd(8'h00, ID);
      $display("test boot done");
      foreach (rows[i]) begin
         low_power_request <= rows[i].pin;
         wr(8'h03, rows[i].ctrl, 1'b1);
         cyc(6);
         chk({7'h00, low_power_mode}, {7'h00, rows[i].lp});
      end
      $display("test power table done");
      module_select_n <= 1'b1;
      cyc(3);
      no_ack(8'ha0);
      module_select_n <= 1'b0;
      cyc(3);
      no_ack(8'hb0);
      $display("test select done");
      fault_event <= 1'b1;
      cyc(1);
      fault_event <= 1'b0;
      cyc(3);
      chk({7'h00, interrupt_drv.oe}, 8'h01);
      rd(8'h01, 8'h02);
      $display("test fault done");
      module_reset_n <= 1'b0;
      cyc(100);
      module_reset_n <= 1'b1;
      cyc(5);
      chk({6'h00, module_ready, low_power_mode}, 8'h03);
      module_reset_n <= 1'b0;
      cyc(420);
      chk({7'h00, module_ready}, 8'h00);
      module_reset_n <= 1'b1;
      wait_ready();
      cyc(3);
      chk({6'h00, interrupt_drv.oe, low_power_mode}, 8'h02);
      rd(8'h02, 8'h00);
      $display("test pin reset done");
      complete_run();
   end
endmodule
